// >>> rtl/motion_event_pkg.sv
// constants, carriers and helpers for the motion event flag register
package motion_event_pkg;
  // -----------------------------------------------------------------
  // register map
  // -----------------------------------------------------------------
  localparam logic [6:0] KEEP_MASK_ADDR = 7'h0C;
  localparam logic [6:0] INT_MASK_ADDR = 7'h0D;
  localparam logic [6:0] EVENT_ADDR = 7'h0E;
  localparam logic [31:0] KEEP_MASK_RESET = 32'h00000000;
  localparam logic [31:0] INT_MASK_RESET = 32'h00000000;
  localparam logic [31:0] EVENT_RESET = 32'h80000000;
  localparam logic [31:0] RESERVED_MASK = 32'h00400000;
  localparam logic [31:0] RDATA_RESET = 32'h00000000;

  // -----------------------------------------------------------------
  // event bit positions
  // -----------------------------------------------------------------
  localparam int EV_GOAL = 0;
  localparam int EV_COMPARE = 1;
  localparam int EV_PEAK = 2;
  localparam int EV_SPEED_ZERO = 3;
  localparam int EV_PHASE_ZERO = 6;
  localparam int EV_TRAP = 9;
  localparam int EV_FREEZE = 10;
  localparam int EV_LEFT_SW = 11;
  localparam int EV_RIGHT_SW = 12;
  localparam int EV_SOFT_L = 13;
  localparam int EV_SOFT_R = 14;
  localparam int EV_HOME = 15;
  localparam int EV_CAPTURE = 16;
  localparam int EV_FULLSTEP = 17;
  localparam int EV_DEVIATION = 18;
  localparam int EV_INDEX = 19;
  localparam int EV_ENC_CAPTURE = 20;
  localparam int EV_SER_FAULT = 21;
  localparam int EV_SER_CONFIG = 23;
  localparam int EV_SER_FLAGS = 24;
  localparam int EV_DATAGRAM = 25;
  localparam int EV_ENC_ZERO = 26;
  localparam int EV_ANGLE_MAX = 27;
  localparam int EV_IN_BAND = 28;
  localparam int EV_STALL = 29;
  localparam int EV_DRIVER = 30;

  // -----------------------------------------------------------------
  // state codes, pins, limit channels
  // -----------------------------------------------------------------
  localparam logic [1:0] CODE_ZERO = 2'h0;
  localparam logic [1:0] CODE_ONE = 2'h1;
  localparam logic [1:0] CODE_TWO = 2'h2;
  localparam int PIN_CNT = 3;
  localparam int PIN_FREEZE = 0;
  localparam int PIN_LEFT = 1;
  localparam int PIN_RIGHT = 2;
  localparam logic [2:0] PIN_RESET = 3'h1;
  localparam int LIMIT_CNT = 4;
  localparam int SER_FLAG_W = 4;
  localparam int DRV_FLAG_W = 8;
  localparam int FLAG_W = SER_FLAG_W + DRV_FLAG_W;

  // -----------------------------------------------------------------
  // carriers
  // -----------------------------------------------------------------
  typedef struct packed {
    logic rd;
    logic wr;
    logic [6:0] addr;
    logic [31:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic left_switch_en;
    logic right_switch_en;
    logic left_soft_en;
    logic right_soft_en;
    logic left_soft_write;
    logic right_soft_write;
  } limit_cfg_s;

  typedef struct packed {
    logic goal_reached;
    logic compare_reached;
    logic peak_speed_hit;
    logic [1:0] speed_sign_state;
    logic [1:0] accel_phase_state;
    logic trap_at_limit;
    logic left_soft_limit_hit;
    logic right_soft_limit_hit;
    logic [31:0] current_speed;
    logic [31:0] break_speed;
    logic home_mismatch;
    logic home_outside_margin;
    logic position_capture_done;
    logic homing_done;
    logic fullstep_engaged;
    logic [31:0] current_position;
    logic [31:0] encoder_position;
    logic [31:0] deviation_limit;
    logic index_event;
    logic encoder_capture_done;
    logic serial_encoder_data_fault;
    logic serial_encoder_config_rx;
    logic [3:0] serial_encoder_status_bits;
    logic datagram_sent;
    logic encoder_speed_zero;
    logic loop_angle_at_max;
    logic loop_deviation_in_band;
    logic stall_stopped;
    logic [7:0] driver_status;
    logic [7:0] driver_status_select;
  } motion_status_s;

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  // one-hot of the code just entered, zero while the code holds
  function automatic logic [2:0] state_entry(input logic [1:0] cur,
                                             input logic [1:0] prev);
    logic [2:0] hot;
    hot = 3'h0;
    if (cur != prev) begin
      case (cur)
        CODE_ZERO: hot = 3'h1;
        CODE_ONE: hot = 3'h2;
        CODE_TWO: hot = 3'h4;
        default: hot = 3'h0;
      endcase
    end
    return hot;
  endfunction : state_entry

  // magnitude of a 33-bit two's complement value
  function automatic logic [32:0] magnitude(input logic [32:0] v);
    return v[32] ? 33'(-v) : v;
  endfunction : magnitude
endpackage : motion_event_pkg

// >>> rtl/event_rise_detect.sv
// rising-edge pulse generator for a vector of same-clock levels
`timescale 1ns/1ns
module event_rise_detect #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic clock_en,
  input wire logic [W-1:0] level,
  output logic [W-1:0] rise
);
  logic [W-1:0] prev_reg;

  // one history flop per bit; rise is combinational on purpose so the
  // event lands in the flag register on the edge after the level rises
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          prev_reg[i] <= 1'b0;
        end else if (clock_en) begin
          prev_reg[i] <= level[i];
        end
      end
      assign rise[i] = level[i] & ~prev_reg[i];
    end
  endgenerate
endmodule : event_rise_detect

// >>> rtl/motion_block_latch.sv
// direction block held from a limit event until it is released
`timescale 1ns/1ns
module motion_block_latch (
  input wire logic clock,
  input wire logic resetn,
  input wire logic clock_en,
  input wire logic trigger,
  input wire logic event_bit,
  input wire logic free,
  output logic blocked_reg
);
  // a new trigger wins over a release in the same cycle
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      blocked_reg <= 1'b0;
    end else if (clock_en) begin
      if (trigger) begin
        blocked_reg <= 1'b1;
      end else if (!event_bit && free) begin
        blocked_reg <= 1'b0;
      end
    end
  end
endmodule : motion_block_latch

// >>> rtl/motion_event_flags.sv
// sticky motion event register with keep mask, interrupt and blocks
`timescale 1ns/1ns
module motion_event_flags
  import motion_event_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic clock_en,
  input wire reg_req_s reg_req,
  output logic [31:0] reg_rdata,
  input wire logic freeze_pin_n,
  input wire logic left_limit_switch,
  input wire logic right_limit_switch,
  input wire limit_cfg_s limit_cfg,
  input wire motion_status_s status,
  output logic [31:0] event_flags,
  output logic interrupt_out,
  output logic inhibit_negative,
  output logic inhibit_positive,
  output logic halted_by_freeze_pin
);
  // -----------------------------------------------------------------
  // declarations
  // -----------------------------------------------------------------
  logic [PIN_CNT-1:0] pin_meta_reg;
  logic [PIN_CNT-1:0] pin_sync_reg;
  logic [31:0] events_reg;
  logic [31:0] events_next;
  logic [31:0] keep_mask_reg;
  logic [31:0] int_mask_reg;
  logic [31:0] int_mask_next;
  logic [31:0] clear_vec;
  logic [31:0] set_vec;
  logic [31:0] level_vec;
  logic [31:0] level_rise;
  logic [FLAG_W-1:0] flag_level;
  logic [FLAG_W-1:0] flag_rise;
  logic [1:0] sign_prev_reg;
  logic [1:0] phase_prev_reg;
  logic [2:0] sign_hot;
  logic [2:0] phase_hot;
  logic [32:0] speed_mag;
  logic [32:0] dev_mag;
  logic trap_level;
  logic dev_level;
  logic [1:0] soft_written_reg;
  logic [LIMIT_CNT-1:0] lim_free;
  logic [LIMIT_CNT-1:0] lim_blocked;
  logic rd_events;

  // -----------------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------------
  // freeze stage resets high so a release does not look like a fall
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pin_meta_reg <= PIN_RESET;
      pin_sync_reg <= PIN_RESET;
    end else if (clock_en) begin
      pin_meta_reg[PIN_FREEZE] <= freeze_pin_n;
      pin_meta_reg[PIN_LEFT] <= left_limit_switch;
      pin_meta_reg[PIN_RIGHT] <= right_limit_switch;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // -----------------------------------------------------------------
  // derived conditions
  // -----------------------------------------------------------------
  // magnitudes are taken at 33 bits so the most negative value is safe
  assign speed_mag = magnitude({status.current_speed[31],
                                status.current_speed});
  assign dev_mag = magnitude(33'({status.current_position[31],
                                  status.current_position}
                                 - {status.encoder_position[31],
                                    status.encoder_position}));
  // a zero break speed disables the trapezoid limit event
  assign trap_level = status.trap_at_limit
                    & (status.break_speed != 32'h00000000)
                    & (speed_mag > {1'b0, status.break_speed});
  assign dev_level = dev_mag > {1'b0, status.deviation_limit};

  // -----------------------------------------------------------------
  // level sources, one per event bit, edge detected
  // -----------------------------------------------------------------
  always_comb begin
    level_vec = 32'h00000000;
    level_vec[EV_GOAL] = status.goal_reached;
    level_vec[EV_COMPARE] = status.compare_reached;
    level_vec[EV_PEAK] = status.peak_speed_hit;
    level_vec[EV_TRAP] = trap_level;
    level_vec[EV_FREEZE] = ~pin_sync_reg[PIN_FREEZE];
    level_vec[EV_LEFT_SW] = pin_sync_reg[PIN_LEFT]
                          & limit_cfg.left_switch_en;
    level_vec[EV_RIGHT_SW] = pin_sync_reg[PIN_RIGHT]
                           & limit_cfg.right_switch_en;
    level_vec[EV_SOFT_L] = status.left_soft_limit_hit;
    level_vec[EV_SOFT_R] = status.right_soft_limit_hit;
    level_vec[EV_HOME] = status.home_mismatch
                       & status.home_outside_margin;
    level_vec[EV_FULLSTEP] = status.fullstep_engaged;
    level_vec[EV_DEVIATION] = dev_level;
    level_vec[EV_INDEX] = status.index_event;
    level_vec[EV_ENC_ZERO] = status.encoder_speed_zero;
    level_vec[EV_ANGLE_MAX] = status.loop_angle_at_max;
    level_vec[EV_IN_BAND] = status.loop_deviation_in_band;
    level_vec[EV_STALL] = status.stall_stopped;
  end

  event_rise_detect #(
    .W(32)
  ) u_level_rise (
    .clock(clock),
    .resetn(resetn),
    .clock_en(clock_en),
    .level(level_vec),
    .rise(level_rise)
  );

  // each serial encoder bit and each selected driver bit counts on its own rising edge
  assign flag_level = {status.driver_status
                       & status.driver_status_select,
                       status.serial_encoder_status_bits};

  event_rise_detect #(
    .W(FLAG_W)
  ) u_flag_rise (
    .clock(clock),
    .resetn(resetn),
    .clock_en(clock_en),
    .level(flag_level),
    .rise(flag_rise)
  );

  // -----------------------------------------------------------------
  // state entry tracking for speed sign and accel phase
  // -----------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sign_prev_reg <= CODE_ZERO;
      phase_prev_reg <= CODE_ZERO;
    end else if (clock_en) begin
      sign_prev_reg <= status.speed_sign_state;
      phase_prev_reg <= status.accel_phase_state;
    end
  end

  assign sign_hot = state_entry(status.speed_sign_state,
                                sign_prev_reg);
  assign phase_hot = state_entry(status.accel_phase_state,
                                 phase_prev_reg);

  // -----------------------------------------------------------------
  // set vector
  // -----------------------------------------------------------------
  always_comb begin
    set_vec = level_rise;
    set_vec[EV_SPEED_ZERO +: 3] = sign_hot;
    set_vec[EV_PHASE_ZERO +: 3] = phase_hot;
    set_vec[EV_CAPTURE] = status.position_capture_done
                        | status.homing_done;
    set_vec[EV_ENC_CAPTURE] = status.encoder_capture_done;
    set_vec[EV_SER_FAULT] = status.serial_encoder_data_fault;
    set_vec[EV_SER_CONFIG] = status.serial_encoder_config_rx;
    set_vec[EV_SER_FLAGS] = |flag_rise[SER_FLAG_W-1:0];
    set_vec[EV_DATAGRAM] = status.datagram_sent;
    set_vec[EV_DRIVER] = |flag_rise[FLAG_W-1:SER_FLAG_W];
  end

  // -----------------------------------------------------------------
  // register access
  // -----------------------------------------------------------------
  assign rd_events = reg_req.rd & addr_hit(reg_req.addr, EVENT_ADDR);
  // protected bits survive the read, all others drop
  assign clear_vec = rd_events ? ~keep_mask_reg
                               : 32'h00000000;
  // an event arriving with the read is kept: set beats clear
  assign events_next = ((events_reg & ~clear_vec) | set_vec)
                     & ~RESERVED_MASK;
  assign int_mask_next = (reg_req.wr
                          && addr_hit(reg_req.addr, INT_MASK_ADDR))
                       ? reg_req.wdata : int_mask_reg;

  // event register, reset leaves only the reset-seen bit
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      events_reg <= EVENT_RESET;
    end else if (clock_en) begin
      events_reg <= events_next;
    end
  end

  // configuration masks
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      keep_mask_reg <= KEEP_MASK_RESET;
      int_mask_reg <= INT_MASK_RESET;
    end else if (clock_en) begin
      if (reg_req.wr && addr_hit(reg_req.addr, KEEP_MASK_ADDR)) begin
        keep_mask_reg <= reg_req.wdata;
      end
      int_mask_reg <= int_mask_next;
    end
  end

  // read data holds until the next read; unmapped reads give zero
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= RDATA_RESET;
    end else if (clock_en && reg_req.rd) begin
      if (addr_hit(reg_req.addr, EVENT_ADDR)) begin
        reg_rdata <= events_reg;
      end else if (addr_hit(reg_req.addr, KEEP_MASK_ADDR)) begin
        reg_rdata <= keep_mask_reg;
      end else if (addr_hit(reg_req.addr, INT_MASK_ADDR)) begin
        reg_rdata <= int_mask_reg;
      end else begin
        reg_rdata <= RDATA_RESET;
      end
    end
  end

  // -----------------------------------------------------------------
  // interrupt
  // -----------------------------------------------------------------
  // built from next values so the pin tracks the flag register exactly
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      interrupt_out <= 1'b0;
    end else if (clock_en) begin
      interrupt_out <= |(events_next & int_mask_next);
    end
  end

  // -----------------------------------------------------------------
  // motion blocking
  // -----------------------------------------------------------------
  // a soft limit must see a fresh position written after it fired
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      soft_written_reg <= 2'h0;
    end else if (clock_en) begin
      if (set_vec[EV_SOFT_L]) begin
        soft_written_reg[0] <= 1'b0;
      end else if (limit_cfg.left_soft_write) begin
        soft_written_reg[0] <= 1'b1;
      end
      if (set_vec[EV_SOFT_R]) begin
        soft_written_reg[1] <= 1'b0;
      end else if (limit_cfg.right_soft_write) begin
        soft_written_reg[1] <= 1'b1;
      end
    end
  end

  assign lim_free[0] = ~pin_sync_reg[PIN_LEFT]
                     | ~limit_cfg.left_switch_en;
  assign lim_free[1] = ~pin_sync_reg[PIN_RIGHT]
                     | ~limit_cfg.right_switch_en;
  assign lim_free[2] = soft_written_reg[0]
                     | ~limit_cfg.left_soft_en;
  assign lim_free[3] = soft_written_reg[1]
                     | ~limit_cfg.right_soft_en;

  // channel i follows event bit EV_LEFT_SW + i
  genvar k;
  generate
    for (k = 0; k < LIMIT_CNT; k++) begin : g_limit
      motion_block_latch u_block (
        .clock(clock),
        .resetn(resetn),
        .clock_en(clock_en),
        .trigger(set_vec[EV_LEFT_SW+k]),
        .event_bit(events_reg[EV_LEFT_SW+k]),
        .free(lim_free[k]),
        .blocked_reg(lim_blocked[k])
      );
    end
  endgenerate

  // freeze is only undone by reset, so it has no clear path
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      halted_by_freeze_pin <= 1'b0;
    end else if (clock_en && set_vec[EV_FREEZE]) begin
      halted_by_freeze_pin <= 1'b1;
    end
  end

  // outputs registered once more; one cycle later than the latches
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      inhibit_negative <= 1'b0;
      inhibit_positive <= 1'b0;
    end else if (clock_en) begin
      inhibit_negative <= lim_blocked[0] | lim_blocked[2]
                        | halted_by_freeze_pin;
      inhibit_positive <= lim_blocked[1] | lim_blocked[3]
                        | halted_by_freeze_pin;
    end
  end

  assign event_flags = events_reg;

  // -----------------------------------------------------------------
  // local decode
  // -----------------------------------------------------------------
  function automatic logic addr_hit(input logic [6:0] a,
                                    input logic [6:0] b);
    return a == b;
  endfunction : addr_hit
endmodule : motion_event_flags

// >>> tb/motion_event_properties.sv
// concurrent checks on the motion event register ports
`timescale 1ns/1ns
module motion_event_properties
  import motion_event_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic clock_en,
  input wire reg_req_s reg_req,
  input wire logic [31:0] reg_rdata,
  input wire logic freeze_pin_n,
  input wire logic left_limit_switch,
  input wire limit_cfg_s limit_cfg,
  input wire motion_status_s status,
  input wire logic [31:0] event_flags,
  input wire logic interrupt_out,
  input wire logic inhibit_negative,
  input wire logic halted_by_freeze_pin
);
  // ----------------------------------------------------------------
  // mask shadows
  // ----------------------------------------------------------------
  logic [31:0] keep_reg;
  logic [31:0] imask_reg;
  wire logic ev_rd = clock_en && reg_req.rd && reg_req.addr == EVENT_ADDR;
  // shadows kept from writes, so no probe into the design is needed
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) keep_reg <= KEEP_MASK_RESET;
    else if (clock_en && reg_req.wr && reg_req.addr == KEEP_MASK_ADDR)
      keep_reg <= reg_req.wdata;
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) imask_reg <= INT_MASK_RESET;
    else if (clock_en && reg_req.wr && reg_req.addr == INT_MASK_ADDR)
      imask_reg <= reg_req.wdata;
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence ev_read;
    ev_rd;
  endsequence
  sequence left_hit;
    $rose(left_limit_switch) && limit_cfg.left_switch_en;
  endsequence
  a_goal_sets: assert property (clock_en && $rose(status.goal_reached)
    |=> event_flags[EV_GOAL]) else $error("goal event missing");
  a_events_sticky: assert property (!ev_rd && clock_en
    |=> ($past(event_flags) & ~event_flags) == 32'h0)
    else $error("event bit fell without read");
  a_sign_entry: assert property (clock_en
    && $changed(status.speed_sign_state)
    && status.speed_sign_state != 2'h3 |=> event_flags[EV_SPEED_ZERO
    + $past(status.speed_sign_state)]) else $error("sign event");
  a_phase_entry: assert property (clock_en
    && $changed(status.accel_phase_state)
    && status.accel_phase_state != 2'h3 |=> event_flags[EV_PHASE_ZERO
    + $past(status.accel_phase_state)]) else $error("phase event");
  a_freeze_halt: assert property ($fell(freeze_pin_n) |-> ##[1:6]
    (event_flags[EV_FREEZE] && halted_by_freeze_pin))
    else $error("freeze not seen");
  a_halt_holds: assert property (halted_by_freeze_pin
    |=> halted_by_freeze_pin) else $error("halt released");
  a_left_block: assert property (left_hit |-> ##[1:6]
    (event_flags[EV_LEFT_SW] && inhibit_negative))
    else $error("left block missing");
  a_read_data: assert property (ev_read |=> reg_rdata == $past(event_flags))
    else $error("read data wrong");
  a_keep_holds: assert property (ev_read
    |=> ($past(event_flags) & $past(keep_reg) & ~event_flags) == 32'h0)
    else $error("kept bit lost");
  a_int_or: assert property (interrupt_out == |(event_flags & imask_reg))
    else $error("interrupt mismatch");
  a_reserved_zero: assert property (!event_flags[22])
    else $error("reserved bit set");
  a_reset_flag: assert property ($rose(resetn) |-> event_flags[31])
    else $error("reset flag missing");
endmodule : motion_event_properties

bind motion_event_flags motion_event_properties u_props (
  .clock(clock), .resetn(resetn), .clock_en(clock_en), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .freeze_pin_n(freeze_pin_n),
  .left_limit_switch(left_limit_switch), .limit_cfg(limit_cfg),
  .status(status), .event_flags(event_flags),
  .interrupt_out(interrupt_out), .inhibit_negative(inhibit_negative),
  .halted_by_freeze_pin(halted_by_freeze_pin)
);

// >>> tb/reg_host.sv
// host side register master for the motion event register
`timescale 1ns/1ns
module reg_host
  import motion_event_pkg::*;
(
  input wire logic clock,
  input wire logic [31:0] reg_rdata,
  output reg_req_s reg_req
);
  initial reg_req = '{rd: 1'b0, wr: 1'b0, addr: 7'h7F, wdata: 32'h0};
  // idle lines show the inverse of the last value, never a stale copy
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clock);
    reg_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask : wr
  // data is taken just after the edge that accepts the read
  task automatic rd(input logic [6:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 32'h0};
    @(posedge clock);
    reg_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 32'hFFFFFFFF};
    #1 d = reg_rdata;
  endtask : rd
endmodule : reg_host

// >>> tb/motion_event_flags_bench.sv
// self-checking bench for the motion event register
`timescale 1ns/1ns
module motion_event_flags_bench
  import motion_event_pkg::*;
;
  // ----------------------------------------------------------------
  // stimulus and instances
  // ----------------------------------------------------------------
  localparam int SRC_BIT [7] = '{0, 16, 25, 29, 30, 18, 9};
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic clock_en = 1'b1;
  logic freeze_pin_n = 1'b1;
  logic left_limit_switch = 1'b0;
  logic right_limit_switch = 1'b0;
  limit_cfg_s cfg = 6'h34;
  motion_status_s st = '0;
  reg_req_s rq;
  logic [31:0] rdata, flags, rd_val;
  logic irq, inh_n, inh_p, halted;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;
  motion_event_flags u_motion_event_flags (.clock(clock), .resetn(resetn),
    .clock_en(clock_en), .reg_req(rq), .reg_rdata(rdata),
    .freeze_pin_n(freeze_pin_n), .left_limit_switch(left_limit_switch),
    .right_limit_switch(right_limit_switch), .limit_cfg(cfg), .status(st),
    .event_flags(flags), .interrupt_out(irq), .inhibit_negative(inh_n),
    .inhibit_positive(inh_p), .halted_by_freeze_pin(halted));
  reg_host u_reg_host (.clock(clock), .reg_rdata(rdata), .reg_req(rq));
  initial begin
    forever #2 clock = ~clock;
  end
  // a hang is cut off well past the roughly 140 cycles needed
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors++;
      stop_test();
    end
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task wt(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : wt
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task stop_test;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_reset;
    u_reg_host.rd(EVENT_ADDR, rd_val);
    chk("reset events", EVENT_RESET, rd_val);
    u_reg_host.rd(EVENT_ADDR, rd_val);
    chk("read cleared", 32'h0, rd_val);
    u_reg_host.rd(KEEP_MASK_ADDR, rd_val);
    chk("keep reset", KEEP_MASK_RESET, rd_val);
    u_reg_host.rd(7'h7F, rd_val);
    chk("unmapped", 32'h0, rd_val);
  endtask : t_reset
  // one source a pass, each a single-cycle rise
  task t_sources;
    for (int i = 0; i < 7; i++) begin
      @(posedge clock);
      case (i)
        0: st.goal_reached <= 1'b1;
        1: st.position_capture_done <= 1'b1;
        2: st.datagram_sent <= 1'b1;
        3: st.stall_stopped <= 1'b1;
        4: begin
          st.driver_status <= 8'h81;
          st.driver_status_select <= 8'h80;
        end
        5: begin
          st.current_position <= 32'hA;
          st.deviation_limit <= 32'h9;
        end
        default: begin
          st.trap_at_limit <= 1'b1;
          st.current_speed <= 32'hFFFFFFFB;
          st.break_speed <= 32'h4;
        end
      endcase
      @(posedge clock);
      st <= '0;
      wt(2);
      rd_val = 32'(flags[SRC_BIT[i]]);
      chk("source", 32'h1, rd_val);
    end
    u_reg_host.rd(EVENT_ADDR, rd_val);
    chk("sources", 32'h62050201, rd_val);
  endtask : t_sources
  task t_codes;
    for (int c = 1; c < 4; c++) begin
      @(posedge clock);
      st.speed_sign_state <= 2'(c % 3);
      st.accel_phase_state <= 2'(c % 3);
      wt(2);
    end
    u_reg_host.rd(EVENT_ADDR, rd_val);
    chk("codes", 32'h1F8, rd_val);
  endtask : t_codes
  task t_keep_int;
    u_reg_host.wr(KEEP_MASK_ADDR, 32'h1);
    u_reg_host.wr(INT_MASK_ADDR, 32'h2);
    @(posedge clock);
    st.goal_reached <= 1'b1;
    st.compare_reached <= 1'b1;
    @(posedge clock);
    st <= '0;
    wt(2);
    chk("irq", 32'h1, 32'(irq));
    u_reg_host.rd(EVENT_ADDR, rd_val);
    chk("kept", 32'h1, flags);
    chk("irq off", 32'h0, 32'(irq));
    u_reg_host.wr(EVENT_ADDR, 32'hFFFFFFFF);
    wt(1);
    chk("no write", 32'h1, flags);
    u_reg_host.wr(KEEP_MASK_ADDR, 32'h0);
    u_reg_host.rd(EVENT_ADDR, rd_val);
    chk("cleared", 32'h0, flags);
  endtask : t_keep_int
  task t_left;
    @(posedge clock);
    left_limit_switch <= 1'b1;
    wt(6);
    chk("left ev", 32'h1, 32'(flags[EV_LEFT_SW]));
    chk("neg block", 32'h1, 32'(inh_n));
    chk("pos free", 32'h0, 32'(inh_p));
    @(posedge clock);
    left_limit_switch <= 1'b0;
    wt(6);
    chk("held", 32'h1, 32'(inh_n));
    u_reg_host.rd(EVENT_ADDR, rd_val);
    wt(3);
    chk("freed", 32'h0, 32'(inh_n));
  endtask : t_left
  task t_soft;
    @(posedge clock);
    st.right_soft_limit_hit <= 1'b1;
    wt(4);
    chk("soft blk", 32'h1, 32'(inh_p));
    u_reg_host.rd(EVENT_ADDR, rd_val);
    chk("soft ev", 32'h4000, rd_val);
    wt(3);
    chk("soft held", 32'h1, 32'(inh_p));
    @(posedge clock);
    cfg.right_soft_write <= 1'b1;
    @(posedge clock);
    cfg.right_soft_write <= 1'b0;
    st <= '0;
    wt(3);
    chk("soft free", 32'h0, 32'(inh_p));
  endtask : t_soft
  task t_freeze;
    @(posedge clock);
    freeze_pin_n <= 1'b0;
    wt(6);
    chk("halt", 32'h1, 32'(halted));
    @(posedge clock);
    freeze_pin_n <= 1'b1;
    u_reg_host.rd(EVENT_ADDR, rd_val);
    chk("freeze ev", 32'h400, rd_val & 32'h400);
    wt(6);
    chk("still", 32'h1, 32'(halted));
    resetn <= 1'b0;
    wt(2);
    resetn <= 1'b1;
    wt(2);
    chk("rearm", 32'h0, 32'(halted));
    chk("reset ev", EVENT_RESET, flags);
  endtask : t_freeze
  initial begin
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    wt(1);
    t_reset();
    t_sources();
    t_codes();
    t_keep_int();
    t_left();
    t_soft();
    t_freeze();
    stop_test();
  end
endmodule : motion_event_flags_bench
